// >>> core/card_cfg_pkg.sv
// constants for the card level translator configuration register
// assumes a single system clock domain and an i2c slave reached by pins
package card_cfg_pkg;
  localparam logic [7:0] DEVICE_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] DEVICE_CONFIG_RESET = 8'h00;
  localparam int REGULATOR_OFF_BIT = 7;
  localparam int PIN_FUNCTION_SELECT_BIT = 6;
  localparam int CARD_RESET_LEVEL_BIT = 5;
  localparam int PATH_FREEZE_BIT = 4;
  localparam int ENABLE_POLARITY_BIT = 3;
  localparam int RESERVED_BIT = 2;
  localparam int SUPPLY_VOLTAGE_SELECT_BIT = 1;
  localparam int DEVICE_ON_BIT = 0;
  localparam logic [7:0] WRITE_MASK = 8'hFB;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
  localparam logic [3:0] BIT_COUNT_INIT = 4'h0;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  // synchroniser reset levels: bus pins idle high, host pins low
  localparam logic [4:0] PIN_SYNC_RESET = 5'h18;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
endpackage : card_cfg_pkg

// >>> core/card_cfg_top.sv
// configuration register of a card level translator, reached as i2c slave
// assumes scl/sda and host pins are asynchronous and sampled via pin_sync;
// sda is open drain: SDA_OE_O high pulls the line low
`timescale 1ns/1ps
module card_cfg_top #(
  parameter logic [6:0] SLAVE_ADDR = card_cfg_pkg::SLAVE_ADDR_DEFAULT // arbitrary value
) (
  input wire logic CLK_SYS_I,        // 250 MHz system clock
  input wire logic RST_I,            // power-on reset, async high
  input wire logic SCL_I,            // serial bus clock
  input wire logic SDA_I,            // serial bus data in
  output logic SDA_O,                // serial bus data out, always low
  output logic SDA_OE_O,             // high pulls sda low
  input wire logic HOST_DATA_I,      // host data level
  input wire logic HOST_CLOCK_I,     // host clock level
  input wire logic HOST_RESET_EN_I,  // host reset/enable pin
  output logic CARD_DATA_PIN_O,      // card data drive level
  output logic CARD_CLOCK_PIN_O,     // card clock level
  output logic CARD_RESET_OUT_O,     // card reset level
  output logic REGULATOR_ON_O,       // card supply regulator enable
  output logic SUPPLY_3V_SEL_O,      // high selects 3 V supply
  output logic DEVICE_ENABLED_O      // translator active
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA, ST_WR_ACK, ST_RD_DATA,
                ST_RD_ACK, ST_WAIT_STOP} state_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  pin_sync #(.WIDTH(5), .RESET_VALUE(card_cfg_pkg::PIN_SYNC_RESET)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i({SCL_I, SDA_I, HOST_DATA_I, HOST_CLOCK_I, HOST_RESET_EN_I}),
    .q_o(pins_s)
  );
  wire scl_s = pins_s[4];
  wire sda_s = pins_s[3];
  wire host_data_s = pins_s[2];
  wire host_clock_s = pins_s[1];
  wire host_rst_en_s = pins_s[0];

  logic scl_prev_q;
  logic sda_prev_q;
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // serial bus engine
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] count_q, count_d;
  logic [7:0] pending_q, pending_d;
  logic pending_valid_q, pending_valid_d;
  logic sda_oe_q, sda_oe_d;
  logic [7:0] config_q, config_d;
  logic [7:0] pins_latched_q, pins_latched_d;

  wire mode_enable_pin = config_q[card_cfg_pkg::PIN_FUNCTION_SELECT_BIT];
  wire freeze = config_q[card_cfg_pkg::PATH_FREEZE_BIT];

  // bit0 shows pin level in enable mode; reserved reads zero
  wire [7:0] read_value = {config_q[card_cfg_pkg::REGULATOR_OFF_BIT:card_cfg_pkg::ENABLE_POLARITY_BIT], 1'b0,
                           config_q[card_cfg_pkg::SUPPLY_VOLTAGE_SELECT_BIT],
                           mode_enable_pin ? host_rst_en_s : config_q[card_cfg_pkg::DEVICE_ON_BIT]};
  wire last_bit = (count_q == card_cfg_pkg::BIT_COUNT_LAST);
  // only the fixed slave address is answered, no pointer byte
  wire addr_match = (shift_q[7:1] == SLAVE_ADDR);

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    count_d = count_q;
    pending_d = pending_q;
    pending_valid_d = pending_valid_q;
    sda_oe_d = sda_oe_q;
    if (stop_cond) begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_cond) begin
      // requests during the internal update go unanswered
      state_d = pending_valid_q ? ST_WAIT_STOP : ST_ADDR;
      count_d = card_cfg_pkg::BIT_COUNT_INIT;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        // bytes shift msb first on scl rise
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            count_d = count_q + 4'h1;
          end
          if (scl_fall && count_q == card_cfg_pkg::BIT_COUNT_BYTE) begin
            count_d = card_cfg_pkg::BIT_COUNT_INIT;
            if (state_q == ST_WR_DATA) begin
              pending_d = shift_q;
              sda_oe_d = 1'b1;
              state_d = ST_WR_ACK;
            end else if (addr_match) begin
              sda_oe_d = 1'b1;
              state_d = ST_ADDR_ACK;
            end else begin
              state_d = ST_WAIT_STOP;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (shift_q[0]) begin
              shift_d = read_value;
              sda_oe_d = ~read_value[7];
              state_d = ST_RD_DATA;
            end else begin
              sda_oe_d = 1'b0;
              state_d = ST_WR_DATA;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            // exactly one data byte; commit waits for stop
            pending_valid_d = 1'b1;
            sda_oe_d = 1'b0;
            state_d = ST_WAIT_STOP;
          end
        end
        ST_RD_DATA: begin
          if (scl_fall) begin
            if (last_bit) begin
              sda_oe_d = 1'b0;
              state_d = ST_RD_ACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
              count_d = count_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // ack or nack both end the single byte read
          if (scl_fall) begin
            state_d = ST_WAIT_STOP;
          end
        end
        ST_WAIT_STOP: begin
          sda_oe_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
    if (stop_cond && pending_valid_q) begin
      pending_valid_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  always_comb begin
    config_d = config_q;
    // write lands on stop; reserved bit masked
    if (stop_cond && pending_valid_q) begin
      config_d = pending_q & card_cfg_pkg::WRITE_MASK;
    end
  end

  // capture host levels while freeze is clear
  always_comb begin
    pins_latched_d = pins_latched_q;
    if (!freeze) begin
      pins_latched_d = {5'h00, host_data_s, host_clock_s, host_rst_en_s};
    end
  end

  // power-on reset restores register and engine; defaults zero
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
      shift_q <= card_cfg_pkg::DEVICE_CONFIG_RESET;
      count_q <= card_cfg_pkg::BIT_COUNT_INIT;
      pending_q <= card_cfg_pkg::DEVICE_CONFIG_RESET;
      pending_valid_q <= 1'b0;
      sda_oe_q <= 1'b0;
      config_q <= card_cfg_pkg::DEVICE_CONFIG_RESET;
      pins_latched_q <= card_cfg_pkg::DEVICE_CONFIG_RESET;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      count_q <= count_d;
      pending_q <= pending_d;
      pending_valid_q <= pending_valid_d;
      sda_oe_q <= sda_oe_d;
      config_q <= config_d;
      pins_latched_q <= pins_latched_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // card side outputs
  // ----------------------------------------------------------------
  // polarity of the enable pin
  wire pin_enable = host_rst_en_s ^ config_q[card_cfg_pkg::ENABLE_POLARITY_BIT];
  wire reset_live = mode_enable_pin ? config_q[card_cfg_pkg::CARD_RESET_LEVEL_BIT] : host_rst_en_s;
  // reset path is frozen only in pass-through mode
  wire reset_level = (freeze && !mode_enable_pin) ? pins_latched_q[0] : reset_live;
  // enable taken from pin; from register otherwise
  wire enabled = mode_enable_pin ? pin_enable : config_q[card_cfg_pkg::DEVICE_ON_BIT];

  logic [4:0] out_q;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      out_q <= 5'h00;
    end else begin
      out_q <= {freeze ? pins_latched_q[2] : host_data_s, freeze ? pins_latched_q[1] : host_clock_s,
                reset_level, enabled, config_q[card_cfg_pkg::SUPPLY_VOLTAGE_SELECT_BIT]};
    end
  end

  assign CARD_DATA_PIN_O = out_q[4];
  assign CARD_CLOCK_PIN_O = out_q[3];
  assign CARD_RESET_OUT_O = out_q[2];
  assign DEVICE_ENABLED_O = out_q[1];
  assign SUPPLY_3V_SEL_O = out_q[0];
  // regulator off bit, translation paths unaffected
  assign REGULATOR_ON_O = ~config_q[card_cfg_pkg::REGULATOR_OFF_BIT];
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_q;
endmodule : card_cfg_top

// >>> core/pin_sync.sv
// two flop synchroniser for a vector of pin inputs
// assumes inputs arrive asynchronously to clk_i
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,              // system clock
  input wire logic rst_i,              // async reset, high
  input wire logic [WIDTH-1:0] d_i,    // raw pin levels
  output logic [WIDTH-1:0] q_o         // synchronised levels
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // reset to the idle pin level so no false edge follows reset
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : pin_sync

// >>> test/card_cfg_properties.sv
// port checker for card_cfg_top
// assumes one clock and an async high reset
`timescale 1ns/1ps
module card_cfg_properties (
  input wire logic CLK_SYS_I, // clock
  input wire logic RST_I, // reset
  input wire logic SCL_I, // bus clock
  input wire logic SDA_I, // bus data
  input wire logic SDA_O, // data value
  input wire logic SDA_OE_O, // pull low
  input wire logic HOST_DATA_I, // host data
  input wire logic HOST_CLOCK_I, // host clock
  input wire logic HOST_RESET_EN_I, // host pin
  input wire logic CARD_DATA_PIN_O, // card data
  input wire logic CARD_CLOCK_PIN_O, // card clock
  input wire logic CARD_RESET_OUT_O, // card reset
  input wire logic REGULATOR_ON_O, // regulator
  input wire logic SUPPLY_3V_SEL_O, // 3 V
  input wire logic DEVICE_ENABLED_O // enable
);
  // ----------
  // port rules
  // ----------
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // eight idle bus cycles rule out a pending stop commit
  chk_sda_only_low:
    assert property (SDA_O == 1'b0) else $error("sda value high");
  chk_reset_values:
    assert property (disable iff (1'b0) RST_I |-> REGULATOR_ON_O && !SUPPLY_3V_SEL_O && !DEVICE_ENABLED_O
      && !SDA_OE_O) else $error("reset values wrong");
  chk_config_quiet:
    assert property ((SCL_I && SDA_I) [*8] |=> $stable(REGULATOR_ON_O) && $stable(SUPPLY_3V_SEL_O))
      else $error("config moved on idle bus");
  chk_ack_scl_low:
    assert property ($changed(SDA_OE_O) |-> !SCL_I) else $error("sda moved with scl high");
  chk_data_follows:
    assert property ($changed(CARD_DATA_PIN_O) |-> CARD_DATA_PIN_O == $past(HOST_DATA_I, 3))
      else $error("card data wrong");
  chk_clock_follows:
    assert property ($changed(CARD_CLOCK_PIN_O) |-> CARD_CLOCK_PIN_O == $past(HOST_CLOCK_I, 3))
      else $error("card clock wrong");
  chk_reset_follows:
    assert property ((SCL_I && SDA_I) [*8] ##0 $changed(CARD_RESET_OUT_O) |->
      CARD_RESET_OUT_O == $past(HOST_RESET_EN_I, 3)) else $error("card reset wrong");
  chk_enable_follows:
    assert property ((SCL_I && SDA_I) [*8] ##0 $changed(DEVICE_ENABLED_O) |->
      $past(HOST_RESET_EN_I, 3) != $past(HOST_RESET_EN_I, 4)) else $error("enable moved alone");
endmodule : card_cfg_properties
bind card_cfg_top card_cfg_properties card_cfg_properties_i (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .HOST_DATA_I(HOST_DATA_I),
  .HOST_CLOCK_I(HOST_CLOCK_I), .HOST_RESET_EN_I(HOST_RESET_EN_I), .CARD_DATA_PIN_O(CARD_DATA_PIN_O),
  .CARD_CLOCK_PIN_O(CARD_CLOCK_PIN_O), .CARD_RESET_OUT_O(CARD_RESET_OUT_O),
  .REGULATOR_ON_O(REGULATOR_ON_O), .SUPPLY_3V_SEL_O(SUPPLY_3V_SEL_O), .DEVICE_ENABLED_O(DEVICE_ENABLED_O));

// >>> test/i2c_host_model.sv
// bus master model for one byte accesses
// assumes the bench resolves a pulled-up sda wire
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clk_i, // clock
  input wire logic sda_i, // sda level
  output logic scl_o, // bus clock
  output logic sda_low_o // pulls sda low
);
  // ---------
  // bus tasks
  // ---------
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // five clocks a phase keeps every phase above four
  task automatic half;
    repeat (5) @(posedge clk_i);
  endtask : half
  task automatic put(input logic b, output logic r);
    half();
    sda_low_o <= !b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : put
  task automatic access(input logic [6:0] a, input logic rd, input logic rs, input logic [7:0] wd,
      output logic [7:0] q, output logic ack);
    logic [17:0] s;
    logic [17:0] g;
    logic [17:0] h;
    s = {a, rd, 1'b1, rd ? 8'hFF : wd, 1'b1};
    h = '1;
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
    for (int i = 17; i >= 0; i--) put(s[i], g[i]);
    // repeated start while the write waits for stop must go unanswered
    if (rs) begin
      half();
      sda_low_o <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      sda_low_o <= 1'b1;
      half();
      scl_o <= 1'b0;
      for (int i = 17; i >= 9; i--) put(s[i] | (i == 10), h[i]);
    end
    half();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
    q = g[8:1];
    ack = !g[9] && (rd || !g[0]) && h[9];
  endtask : access
endmodule : i2c_host_model

// >>> test/testbench.sv
// self-checking bench for card_cfg_top
// assumes i2c_host_model and a pulled-up sda
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] ADDR = 7'h15; // arbitrary value
  logic clk, rst, hd, hc, hr, fd, fc, fr;
  logic [7:0] cfg, v;
  logic [7:0] corner [4];
  int err_count, compares, seed;
  wire scl, sda_low, sda, sda_o, sda_oe, cd, cc, cr, reg_on, v3, en;
  assign sda = !(sda_low || sda_oe);
  card_cfg_top #(.SLAVE_ADDR(ADDR)) card_cfg_top_i (.CLK_SYS_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .HOST_DATA_I(hd), .HOST_CLOCK_I(hc), .HOST_RESET_EN_I(hr),
    .CARD_DATA_PIN_O(cd), .CARD_CLOCK_PIN_O(cc), .CARD_RESET_OUT_O(cr), .REGULATOR_ON_O(reg_on),
    .SUPPLY_3V_SEL_O(v3), .DEVICE_ENABLED_O(en));
  i2c_host_model i2c_host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // ------------
  // checks
  // ------------
  function automatic logic [7:0] exp_pins(input logic [7:0] c);
    exp_pins = {2'h0, !c[7], c[1], c[6] ? hr ^ c[3] : c[0], c[4] && !c[6] ? fr : (c[6] ? c[5] : hr),
      c[4] ? fd : hd, c[4] ? fc : hc};
  endfunction : exp_pins
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic verify;
    logic [7:0] q;
    logic k;
    check({2'h0, reg_on, v3, en, cr, cd, cc}, exp_pins(cfg));
    i2c_host_model_i.access(ADDR, 1'b1, 1'b0, 8'h00, q, k);
    check({7'h00, k}, 8'h01);
    check(q, {cfg[7:3], 1'b0, cfg[1], cfg[6] ? hr : cfg[0]});
  endtask : verify
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic rs);
    logic [7:0] q;
    logic k;
    i2c_host_model_i.access(a, 1'b0, rs, d, q, k);
    check({7'h00, k}, {7'h00, a == ADDR});
    // freeze captures pin levels only when it is newly set
    if (k && d[4] && !cfg[4]) {fd, fc, fr} = {hd, hc, hr};
    if (k) cfg = d & 8'hFB;
    repeat (8) @(posedge clk);
  endtask : wr
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    seed = 55083;
    corner = '{8'hFF, 8'h00, 8'h4D, 8'h37};
    // nba so the async reset branch is already waiting when the edge comes
    rst <= 1'b1;
    {hd, hc, hr, fd, fc, fr} = 6'h19;
    cfg = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    verify();
    for (int i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      {hd, hc, hr} <= v[2:0];
      repeat (6) @(posedge clk);
      verify();
      v = (i < 4) ? corner[i] : 8'($random(seed));
      if (cfg[4]) v[4] = 1'b0;
      wr(ADDR, v, i[0]);
      verify();
      {hd, hr} <= {!hd, !hr};
      repeat (6) @(posedge clk);
      verify();
      $display("test %0d done", i);
    end
    wr(ADDR ^ 7'h01, ~cfg, 1'b0);
    verify();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg = 8'h00;
    repeat (4) @(posedge clk);
    verify();
    give_verdict();
  end
endmodule : testbench
